// *** oec_pkg.sv ***
/*
 * oec_pkg: shared types and constants of the output-enable controller.
 * assumes a 10 MHz controller clock; setpoints are opaque words.
 */
package oec_pkg;

	// ==========================================================
	// widths and timing
	localparam int OEC_SET_W        = 16;
	localparam int OEC_CLK_HZ       = 10_000_000;
	localparam int OEC_LATCH_US     = 100;
	localparam int OEC_LATCH_CYC    = (OEC_LATCH_US * (OEC_CLK_HZ / 1000)
		+ 999) / 1000;
	localparam int OEC_PACK_MS      = 500;
	localparam int OEC_PACK_CYC     = OEC_PACK_MS * (OEC_CLK_HZ / 1000);
	localparam int OEC_LOW_PROT     = 1;
	localparam logic [15:0] OEC_ERR_CMD = 16'hFF9C;

	// ==========================================================
	// modes and commands
	typedef enum logic [2:0] {
		high_level_on_mode,
		low_level_on_mode,
		high_level_off_mode,
		low_level_off_mode,
		latched_low_off_mode,
		pin_disabled_mode
	} oec_pin_mode_t;

	localparam oec_pin_mode_t OEC_PIN_MODE_RST = high_level_off_mode;

	typedef enum logic [2:0] {
		grp_interface,
		grp_serial,
		grp_limits,
		grp_contrast,
		grp_output
	} oec_group_t;

	typedef enum logic [1:0] {
		pk_backup,
		pk_erase_main,
		pk_write_back,
		pk_erase_backup
	} oec_pack_step_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [OEC_SET_W-1:0] volt;
		logic [OEC_SET_W-1:0] curr;
		logic [OEC_SET_W-1:0] vprot;
		logic [OEC_SET_W-1:0] cprot;
	} oec_setp_t;

	typedef struct packed {
		logic [4:0] gpib_addr;
		logic       language;
		logic [7:0] sys_set;
		logic [2:0] serial_state;
		logic [3:0] baud;
		logic       pace;
		logic       echo;
		logic [OEC_SET_W-1:0] vlim;
		logic [OEC_SET_W-1:0] clim;
		logic [OEC_SET_W-1:0] vprot_max;
		logic [OEC_SET_W-1:0] cprot_max;
		logic [3:0] contrast;
		logic       background;
		logic [1:0] load_type;
	} oec_cfg_t;

endpackage

// *** oec_pack_seq.sv ***
/*
 * oec_pack_seq: flash pack sequencer, four timed steps.
 * assumes the storage performs each step while the step code is shown.
 */
`timescale 1ns/1ps
module oec_pack_seq #(
	parameter int STEP_CYC = oec_pkg::OEC_PACK_CYC / 4
) (
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic                    start,
	output logic                         busy,
	output oec_pkg::oec_pack_step_t      step,
	output logic                         done
);
	import oec_pkg::*;

	// ==========================================================
	// step sequence; total stays within the pack time
	logic [31:0]     cnt_r;
	oec_pack_step_t  step_r;
	logic            busy_r;
	logic            done_r;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_r  <= '0;
			step_r <= pk_backup;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (!busy_r)
			begin
				if (start)
				begin
					busy_r <= 1'b1;
					step_r <= pk_backup;
					cnt_r  <= '0;
				end
			end
			else if (cnt_r == 32'(STEP_CYC - 1))
			begin
				cnt_r <= '0;
				unique case (step_r)
					pk_backup:     step_r <= pk_erase_main;
					pk_erase_main: step_r <= pk_write_back;
					pk_write_back: step_r <= pk_erase_backup;
					pk_erase_backup:
					begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
					end
				endcase
			end
			else
				cnt_r <= cnt_r + 32'h1;
		end
	end

	assign busy = busy_r;
	assign step = step_r;
	assign done = done_r;

endmodule // oec_pack_seq

// *** oec_output_ctrl.sv ***
/*
 * oec_output_ctrl: output enable, setpoint save/restore, remote pin
 * modes, group saves to storage, pack, list count check.
 * assumes commands are single-cycle strobes, synchronous to clk.
 */
// Functional notes
// - high-on mode: pin high on, low off
// - low-on mode: pin low on, high off
// - high-off mode: high forces off, else request
// - low-off mode: low forces off, else request
// - latched mode: low 100us turns off
// - disabled mode ignores the pin
// - level-on modes ignore key and commands
// - default pin mode is high-off
// - pin mode persists only after interface save
// - mode query returns configured mode
// - state query: 1 on, 0 off
// - state command boolean enables or disables
// - local-to-remote keeps output state
// - output-off first saves programmed setpoints; active loads skip the save
// - off: zero main channel, low protection; active loads keep their setpoints
// - output-on restores saved setpoints
// - setpoint queries return saved values while off
// - interface and serial group save contents
// - limits, contrast, output group contents
// - pack: backup, erase, write, erase backup
// - sample list needs loop count one
`timescale 1ns/1ps
module oec_output_ctrl #(
	parameter int LATCH_CYC = oec_pkg::OEC_LATCH_CYC,
	parameter int PACK_CYC  = oec_pkg::OEC_PACK_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic                    remote_pin,
	input  wire logic                    key_standby,
	input  wire logic                    out_cmd_stb,
	input  wire logic                    out_cmd_on,
	input  wire logic                    remote_pin_mode_command,
	input  oec_pkg::oec_pin_mode_t       pin_mode_in,
	input  wire logic                    is_remote,
	input  wire logic                    current_source,
	input  wire logic                    active_load,
	input  wire logic                    setp_wr,
	input  oec_pkg::oec_setp_t           setp_in,
	input  oec_pkg::oec_cfg_t            cfg_live,
	input  oec_pkg::oec_cfg_t            cfg_nv,
	input  oec_pkg::oec_pin_mode_t       pin_mode_nv,
	input  wire logic                    config_save_command,
	input  oec_pkg::oec_group_t          save_group,
	input  wire logic                    pack_cmd,
	input  wire logic                    list_run,
	input  wire logic                    list_has_sample,
	input  wire logic [15:0]             list_count,
	output logic                         out_en,
	output oec_pkg::oec_pin_mode_t       pin_mode,
	output oec_pkg::oec_setp_t           setp_work,
	output oec_pkg::oec_setp_t           setp_query,
	output oec_pkg::oec_cfg_t            cfg_store,
	output oec_pkg::oec_pin_mode_t       pin_mode_store,
	output logic                         store_wr,
	output logic                         pack_busy,
	output oec_pkg::oec_pack_step_t      pack_step,
	output logic                         pack_done,
	output logic                         list_go,
	output logic                         err_stb,
	output logic [15:0]                  err_code
);
	import oec_pkg::*;

	// ==========================================================
	// state
	logic            out_r;
	oec_pin_mode_t   mode_r;
	oec_setp_t       saved_r;
	oec_setp_t       work_r;
	oec_cfg_t        store_r;
	oec_pin_mode_t   mode_store_r;
	logic            store_wr_r;
	logic            loaded_r;
	logic [31:0]     low_cnt_r;
	logic            low_trip;
	logic            req_valid;
	logic            req_on;
	logic            out_nxt;
	logic            err_r;
	logic            go_r;
	logic            level_mode;
	logic            prev_remote_r;

	// ==========================================================
	// pin mode and power-up load
	// the stored mode is caught after reset release, not under reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_r   <= OEC_PIN_MODE_RST;
			loaded_r <= 1'b0;
		end
		else if (!loaded_r)
		begin
			mode_r   <= pin_mode_nv;
			loaded_r <= 1'b1;
		end
		else if (remote_pin_mode_command)
			mode_r <= pin_mode_in;
	end

	assign pin_mode = mode_r;

	// ==========================================================
	// latched mode low timer
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			low_cnt_r <= '0;
		else if (remote_pin || mode_r != latched_low_off_mode)
			low_cnt_r <= '0;
		else if (low_cnt_r != 32'(LATCH_CYC))
			low_cnt_r <= low_cnt_r + 32'h1;
	end

	assign low_trip = (low_cnt_r == 32'(LATCH_CYC - 1)) && !remote_pin;

	// ==========================================================
	// output state
	assign level_mode = (mode_r == high_level_on_mode) ||
		(mode_r == low_level_on_mode);
	// key toggles; command sets from its boolean
	assign req_valid = (out_cmd_stb || key_standby) && !level_mode;
	assign req_on    = out_cmd_stb ? out_cmd_on : !out_r;

	always_comb
	begin
		out_nxt = out_r;
		if (req_valid)
			out_nxt = req_on;
		unique case (mode_r)
			high_level_on_mode:   out_nxt = remote_pin;
			low_level_on_mode:    out_nxt = !remote_pin;
			high_level_off_mode:
				if (remote_pin)
					out_nxt = 1'b0;
			low_level_off_mode:
				if (!remote_pin)
					out_nxt = 1'b0;
			latched_low_off_mode:
				if (low_trip)
					out_nxt = 1'b0;
			pin_disabled_mode:    out_nxt = out_nxt;
			default:              out_nxt = out_nxt;
		endcase
	end

	// remote entry is not an event here, so state simply holds
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			out_r         <= 1'b1;
			prev_remote_r <= 1'b0;
		end
		else
		begin
			prev_remote_r <= is_remote;
			out_r         <= out_nxt;
		end
	end

	assign out_en = out_r;

	// ==========================================================
	// setpoints: save on off, restore on on
	// active loads keep their setpoints; the host zeroes current itself
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			saved_r <= '0;
			work_r  <= '0;
		end
		else if (out_r && !out_nxt)
		begin
			if (!active_load)
			begin
				saved_r <= work_r;
				work_r  <= work_r;
				if (current_source)
				begin
					work_r.curr  <= '0;
					work_r.vprot <= OEC_SET_W'(OEC_LOW_PROT);
				end
				else
				begin
					work_r.volt  <= '0;
					work_r.cprot <= OEC_SET_W'(OEC_LOW_PROT);
				end
			end
		end
		else if (!out_r && out_nxt)
		begin
			if (!active_load)
				work_r <= saved_r;
		end
		else if (setp_wr)
		begin
			if (out_r || active_load)
				work_r <= setp_in;
			else
				saved_r <= setp_in;
		end
	end

	assign setp_work  = work_r;
	assign setp_query = (!out_r && !active_load) ? saved_r : work_r;

	// ==========================================================
	// group saves into the storage image
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			store_r      <= '0;
			mode_store_r <= OEC_PIN_MODE_RST;
			store_wr_r   <= 1'b0;
		end
		else if (!loaded_r)
		begin
			store_r      <= cfg_nv;
			mode_store_r <= pin_mode_nv;
			store_wr_r   <= 1'b0;
		end
		else
		begin
			store_wr_r <= config_save_command;
			if (config_save_command)
			begin
				unique case (save_group)
					grp_interface:
					begin
						store_r.gpib_addr <= cfg_live.gpib_addr;
						store_r.language  <= cfg_live.language;
						store_r.sys_set   <= cfg_live.sys_set;
						mode_store_r      <= mode_r;
					end
					grp_serial:
					begin
						store_r.serial_state <= cfg_live.serial_state;
						store_r.baud         <= cfg_live.baud;
						store_r.pace         <= cfg_live.pace;
						store_r.echo         <= cfg_live.echo;
					end
					grp_limits:
					begin
						store_r.vlim      <= cfg_live.vlim;
						store_r.clim      <= cfg_live.clim;
						store_r.vprot_max <= cfg_live.vprot_max;
						store_r.cprot_max <= cfg_live.cprot_max;
					end
					grp_contrast:
					begin
						store_r.contrast   <= cfg_live.contrast;
						store_r.background <= cfg_live.background;
					end
					grp_output:
						store_r.load_type <= cfg_live.load_type;
					default:
						store_r <= store_r;
				endcase
			end
		end
	end

	assign cfg_store      = store_r;
	assign pin_mode_store = mode_store_r;
	assign store_wr       = store_wr_r;

	// ==========================================================
	// pack sequencer
	oec_pack_seq #(
		.STEP_CYC (PACK_CYC / 4)
	) u_pack (
		.clk    (clk),
		.arst_n (arst_n),
		.start  (pack_cmd),
		.busy   (pack_busy),
		.step   (pack_step),
		.done   (pack_done)
	);

	// ==========================================================
	// list start check
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			err_r <= 1'b0;
			go_r  <= 1'b0;
		end
		else
		begin
			err_r <= list_run && list_has_sample && list_count != 16'h0001;
			go_r  <= list_run && !(list_has_sample && list_count != 16'h0001);
		end
	end

	assign err_stb  = err_r;
	assign err_code = OEC_ERR_CMD;
	assign list_go  = go_r;

endmodule // oec_output_ctrl

// *** oec_assertions.sv ***
/*
 * oec_assertions: port checks of oec_output_ctrl.
 * assumes one clock and the active-low asynchronous reset.
 */
`timescale 1ns/1ps
module oec_assertions
	import oec_pkg::*;
(
	input	wire logic		clk,
	input	wire logic		arst_n,
	input	wire logic		remote_pin,
	input	wire logic		key_standby,
	input	wire logic		out_cmd_stb,
	input	wire logic		out_cmd_on,
	input	wire logic		remote_pin_mode_command,
	input	oec_pkg::oec_pin_mode_t	pin_mode,
	input	wire logic		out_en,
	input	wire logic		list_run,
	input	wire logic		list_has_sample,
	input	wire logic [15:0]	list_count,
	input	wire logic		err_stb,
	input	wire logic [15:0]	err_code,
	input	wire logic		config_save_command,
	input	wire logic		store_wr,
	input	wire logic		pack_cmd,
	input	wire logic		pack_busy,
	input	wire logic		pack_done
);
	// ==========================================================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// a mode load in the same cycle may legally win, so skip those
	wire q = !remote_pin_mode_command;

	hon_follow_a: assert property (q &&
		pin_mode == high_level_on_mode |=> out_en == $past(remote_pin))
		else $error("high-on output mismatch");
	lon_follow_a: assert property (q &&
		pin_mode == low_level_on_mode |=> out_en == !$past(remote_pin))
		else $error("low-on output mismatch");
	high_level_off_mode_force_a: assert property (q && remote_pin &&
		pin_mode == high_level_off_mode |=> !out_en)
		else $error("high-off not forced");
	low_level_off_mode_force_a: assert property (q && !remote_pin &&
		pin_mode == low_level_off_mode |=> !out_en)
		else $error("low-off not forced");
	pin_ignored_a: assert property (q && !key_standby &&
		!out_cmd_stb && pin_mode == pin_disabled_mode |=> $stable(out_en))
		else $error("disabled pin moved output");
	cmd_state_a: assert property (q && out_cmd_stb &&
		!key_standby && pin_mode == pin_disabled_mode
		|=> out_en == $past(out_cmd_on)) else $error("state cmd ignored");
	list_err_a: assert property (list_run && list_has_sample
		|=> err_stb == ($past(list_count) != 16'h0001))
		else $error("loop count check wrong");
	err_code_a: assert property (err_stb |->
		err_code == 16'hFF9C) else $error("wrong error code");
	save_pulse_a: assert property (config_save_command
		|=> store_wr) else $error("no store write");
	pack_start_a: assert property (pack_cmd && !pack_busy
		|=> pack_busy) else $error("pack not started");
	pack_done_a: assert property (pack_done |=> !pack_done)
		else $error("pack done too long");

	cover property (pin_mode == latched_low_off_mode && $fell(out_en));
	cover property (pack_done);
	cover property (err_stb);
endmodule // oec_assertions

// *** oec_pin_src.sv ***
/*
 * oec_pin_src: remote on/off pin source.
 * assumes a pull-up on the pin, so open reads high.
 */
`timescale 1ns/1ps
module oec_pin_src (
	input	wire logic	clk,
	input	wire logic	short_pin,
	output	logic		remote_pin
);
	// ==========================================================
	// pin level: a short pulls low, open floats high
	always_ff @(posedge clk)
	begin
		remote_pin <= !short_pin;
	end
endmodule // oec_pin_src

// *** tb_top.sv ***
/*
 * tb_top: scenarios for oec_output_ctrl with the pin source.
 * assumes oec_pkg, oec_pin_src and oec_assertions compiled first.
 */
`timescale 1ns/1ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
	import oec_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic		clk = 0, arst_n = 0, short_pin = 1, remote_pin;
	logic		key_standby = 0, out_cmd_stb = 0, out_cmd_on = 0;
	logic		mode_cmd = 0, is_remote = 0, cur_src = 0, setp_wr = 0;
	logic		save_cmd = 0, pack_cmd = 0, list_run = 0, has_smp = 1;
	oec_pin_mode_t	mode_in = high_level_off_mode, pin_mode, pin_mode_store;
	oec_group_t	group = grp_interface;
	oec_setp_t	setp_in = 64'h1234_0567_0100_0200, setp_work, setp_query;
	oec_cfg_t	cfg_live = '1, cfg_store;
	logic [15:0]	list_count = 16'h0001, err_code;
	logic		out_en, store_wr, pack_busy, pack_done, list_go, err_stb;
	logic		act_load = 0;
	oec_pack_step_t	pack_step;
	int		fail_count = 0, checks_done = 0, cyc = 0;

	oec_pin_src u_oec_pin_src (.clk, .short_pin, .remote_pin);
	// short counts keep the latch and pack runs brief
	oec_output_ctrl #(.LATCH_CYC(4), .PACK_CYC(16)) u_oec_output_ctrl (
		.clk, .arst_n, .remote_pin, .key_standby, .out_cmd_stb,
		.out_cmd_on, .remote_pin_mode_command(mode_cmd),
		.pin_mode_in(mode_in), .is_remote, .current_source(cur_src),
		.active_load(act_load), .setp_wr, .setp_in, .cfg_live, .cfg_nv('0),
		.pin_mode_nv(high_level_off_mode), .config_save_command(save_cmd),
		.save_group(group), .pack_cmd, .list_run, .list_has_sample(has_smp),
		.list_count, .out_en, .pin_mode, .setp_work, .setp_query,
		.cfg_store, .pin_mode_store, .store_wr, .pack_busy,
		.pack_step(pack_step), .pack_done, .list_go, .err_stb, .err_code);

	always #50 clk = ~clk;

	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// one strobe with its data; 0 out, 1 mode, 2 save, 3 pack, 4 list, 5 key
	task automatic fire(int k, logic [2:0] d);
		@(posedge clk);
		out_cmd_on <= d[0];
		mode_in <= oec_pin_mode_t'(d);
		group <= oec_group_t'(d);
		list_count <= {13'h0000, d};
		case (k)
			0: out_cmd_stb <= 1'b1;
			1: mode_cmd <= 1'b1;
			2: save_cmd <= 1'b1;
			3: pack_cmd <= 1'b1;
			4: list_run <= 1'b1;
			default: key_standby <= 1'b1;
		endcase
		@(posedge clk);
		{out_cmd_stb, mode_cmd, save_cmd, pack_cmd, list_run} <= '0;
		key_standby <= 1'b0;
		#1;
	endtask

	task automatic pin(logic lo, int n);
		@(posedge clk);
		short_pin <= lo;
		step(n);
	endtask

	task automatic s_high_level_off_mode();
		fire(0, 0); `CK(out_en, 1'b0)
		fire(0, 1); `CK(out_en, 1'b1)
		pin(0, 3); `CK(out_en, 1'b0)
		fire(0, 1); `CK(out_en, 1'b0)
		pin(1, 3);
	endtask

	task automatic s_modes();
		for (int m = 0; m < 6; m++)
		begin
			fire(1, m[2:0]); `CK(pin_mode, oec_pin_mode_t'(m))
		end
		fire(0, 1);
		pin(0, 3); `CK(out_en, 1'b1)
		pin(1, 3); `CK(out_en, 1'b1)
		fire(5, 0); `CK(out_en, 1'b0)
	endtask

	task automatic s_setp();
		fire(0, 1);
		for (int cs = 0; cs < 2; cs++)
		begin
			@(posedge clk);
			cur_src <= cs[0];
			setp_wr <= 1'b1;
			@(posedge clk);
			setp_wr <= 1'b0;
			fire(0, 0); `CK(setp_query, setp_in)
			`CK(cs ? setp_work.curr : setp_work.volt, 16'h0000)
			`CK(cs ? setp_work.vprot : setp_work.cprot, 16'h0001)
			@(posedge clk);
			is_remote <= ~is_remote;
			step(2); `CK(out_en, 1'b0)
			fire(0, 1); `CK(setp_work, setp_in)
		end
		// active load: host zeroes current itself, off keeps setpoints
		@(posedge clk);
		act_load <= 1'b1;
		fire(0, 0); `CK(setp_work, setp_in)
		`CK(setp_query, setp_in)
		`CK(out_en, 1'b0)
		fire(0, 1);
		@(posedge clk);
		act_load <= 1'b0;
	endtask

	task automatic s_level();
		fire(1, 0);
		pin(0, 3); `CK(out_en, 1'b1)
		fire(0, 0); `CK(out_en, 1'b1)
		fire(5, 0); `CK(out_en, 1'b1)
		pin(1, 3); `CK(out_en, 1'b0)
		fire(0, 1); `CK(out_en, 1'b0)
		fire(1, 1);
		step(2); `CK(out_en, 1'b1)
		pin(0, 3); `CK(out_en, 1'b0)
		fire(1, 3);
		fire(0, 1); `CK(out_en, 1'b1)
		pin(1, 3); `CK(out_en, 1'b0)
	endtask

	task automatic s_latch();
		fire(1, 4);
		pin(0, 2);
		fire(0, 1); `CK(out_en, 1'b1)
		pin(1, 2);
		pin(0, 0);
		pin(1, 2);
		pin(0, 3); `CK(out_en, 1'b1)
		pin(1, 8); `CK(out_en, 1'b0)
		pin(0, 3); `CK(out_en, 1'b0)
		fire(0, 1); `CK(out_en, 1'b1)
	endtask

	task automatic s_save();
		`CK(pin_mode_store, high_level_off_mode)
		for (int g = 0; g < 5; g++)
		begin
			fire(2, g[2:0]); `CK(store_wr, 1'b1)
		end
		`CK(pin_mode_store, latched_low_off_mode)
		`CK(cfg_store, cfg_live)
		// a mode change without an interface save leaves the image alone
		fire(1, 2);
		fire(2, 1); `CK(pin_mode_store, latched_low_off_mode)
	endtask

	task automatic s_pack_list();
		int n;
		n = 0;
		fire(3, 0); `CK(pack_busy, 1'b1)
		fire(3, 0);
		while (pack_done !== 1'b1 && n < 40)
		begin
			step(1);
			n++;
			if (n == 6)
				`CK(pack_step, pk_write_back)
		end
		`CK(pack_done, 1'b1)
		`CK(pack_busy, 1'b0)
		`CK(n, 14)
		fire(4, 1); `CK({err_stb, list_go}, 2'b01)
		fire(4, 2); `CK({err_stb, err_code}, 17'h1FF9C)
		@(posedge clk);
		has_smp <= 1'b0;
		fire(4, 2); `CK({err_stb, list_go}, 2'b01)
	endtask

	task automatic summarize();
		$display("checks %0d fails %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			fail_count++;
			summarize();
		end
	end

	initial
	begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		step(2); `CK(out_en, 1'b1)
		`CK(pin_mode, high_level_off_mode)
		s_high_level_off_mode();
		s_modes();
		s_setp();
		s_level();
		s_latch();
		s_save();
		s_pack_list();
		summarize();
	end
endmodule // tb_top

bind oec_output_ctrl oec_assertions u_oec_assertions (.clk, .arst_n,
	.remote_pin, .key_standby, .out_cmd_stb, .out_cmd_on,
	.remote_pin_mode_command, .pin_mode, .out_en, .list_run,
	.list_has_sample, .list_count, .err_stb, .err_code,
	.config_save_command, .store_wr, .pack_cmd, .pack_busy, .pack_done);
